//--- design/dlc_top.sv
/*
 * Digital loop configuration: register port, lock window check,
 * bandwidth and damping set selection, feedback value and holdover.
 * Assumes register port and loop signals share SYS_CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module dlc_top
	import dlc_pkg::*;
#(
	parameter int HIST_CYCLES = HIST_CYC
) (
	// Clock and reset
	input  wire logic                SYS_CLK,
	input  wire logic                RESET,
	// Register port
	input  wire logic [15:0]         REG_ADDR,
	input  wire logic [7:0]          REG_WDATA,
	input  wire logic                REG_WR,
	input  wire logic                REG_RD,
	output logic [7:0]               REG_RDATA,
	// Loop measurements
	input  wire logic [PHERR_W-1:0]  PHASE_ERR,
	input  wire logic                PHASE_ERR_VALID,
	input  wire logic [FREQ_W-1:0]   FREQ_WORD,
	input  wire logic                HOLDOVER,
	// Loop settings
	output logic                     LOCKED,
	output logic [3:0]               BW_CODE,
	output logic [3:0]               DAMPING,
	output logic [2:0]               GAIN_HALVES,
	output logic [15:0]              SLOPE_LIMIT,
	output logic [29:0]              FB_VALUE,
	// Holdover
	output logic                     HOLD_ACTIVE,
	output logic [FREQ_W-1:0]        HOLD_FREQ
);
	import dlc_pkg::*;

	logic [2:0]  trkd_q, acqd_q;
	logic [1:0]  gain_q, slope_q, hold_q;
	logic        avg_q, fast_q, lock_q;
	logic [7:0]  win_q;
	logic [8:0]  int_q;
	logic [20:0] frac_q;
	logic [3:0]  trkbw_q, acquire_bandwidth_code_q;
	logic [7:0]  rdata_q;
	logic [TICK_W-1:0] tick_cnt_q;

	// Decode a damping code; 5 exists only in the acquire set
	function automatic logic [3:0] damp_val(input logic [2:0] c,
		input logic acq);
		damp_val = (c == 3'h1) ? 4'h1 :
			(c == 3'h2) ? 4'h2 :
			(c == 3'h3 && acq) ? 4'h5 :
			(c == 3'h4) ? 4'ha : 4'h0;
	endfunction : damp_val

	// ----------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------
	wire wr_mode = REG_WR && REG_ADDR == ADDR_MODE;
	wire wr_win  = REG_WR && REG_ADDR == ADDR_WIN;
	wire wr_ihi  = REG_WR && REG_ADDR == ADDR_INT_HI;
	wire wr_ilo  = REG_WR && REG_ADDR == ADDR_INT_LO;
	wire wr_fhi  = REG_WR && REG_ADDR == ADDR_FRAC_HI;
	wire wr_fmd  = REG_WR && REG_ADDR == ADDR_FRAC_MID;
	wire wr_flo  = REG_WR && REG_ADDR == ADDR_FRAC_LO;
	wire wr_bw   = REG_WR && REG_ADDR == ADDR_BW;
	wire wr_damp = REG_WR && REG_ADDR == ADDR_DAMP;

	// Read mux; reserved bits and unmapped addresses read zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (REG_ADDR)
			ADDR_MODE: rd_mux = {slope_q, 1'b0, hold_q, 1'b0,
				avg_q, fast_q};
			ADDR_WIN:      rd_mux = win_q;
			ADDR_INT_HI:   rd_mux = {7'h00, int_q[8]};
			ADDR_INT_LO:   rd_mux = int_q[7:0];
			ADDR_FRAC_HI:  rd_mux = {3'h0, frac_q[20:16]};
			ADDR_FRAC_MID: rd_mux = frac_q[15:8];
			ADDR_FRAC_LO:  rd_mux = frac_q[7:0];
			ADDR_BW:       rd_mux = {trkbw_q, acquire_bandwidth_code_q};
			ADDR_DAMP:     rd_mux = {trkd_q, acqd_q, gain_q};
			default:       rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------
	// Writes take reserved codes as given; slope and damping then decode to zero, hold mode 2 to the live word
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			slope_q <= RST_SLOPE;
			hold_q  <= RST_HOLD;
			avg_q   <= RST_AVG;
			fast_q  <= RST_FAST;
		end else if (wr_mode) begin
			slope_q <= REG_WDATA[SLOPE_LSB +: 2];
			hold_q  <= REG_WDATA[HOLD_LSB +: 2];
			avg_q   <= REG_WDATA[AVG_BIT];
			fast_q  <= REG_WDATA[FAST_BIT];
		end
	end

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			trkd_q <= RST_TRKD;
			acqd_q <= RST_ACQD;
			gain_q <= RST_GAIN;
		end else if (wr_damp) begin
			trkd_q <= REG_WDATA[TRKD_LSB +: 3];
			acqd_q <= REG_WDATA[ACQD_LSB +: 3];
			gain_q <= REG_WDATA[GAIN_LSB +: 2];
		end
	end

	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			trkbw_q <= RST_BW;
			acquire_bandwidth_code_q <= RST_BW;
		end else if (wr_bw) begin
			trkbw_q <= REG_WDATA[TRKBW_LSB +: 4];
			acquire_bandwidth_code_q <= REG_WDATA[ACQUIRE_BANDWIDTH_CODE_LSB +: 4];
		end
	end

	// Window zero never locks; software must avoid it
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) win_q <= RST_WIN;
		else if (wr_win) win_q <= REG_WDATA;
	end

	// Feedback value, one byte lane per address
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			int_q  <= RST_INT;
			frac_q <= RST_FRAC;
		end else begin
			if (wr_ihi) int_q[8]       <= REG_WDATA[0];
			if (wr_ilo) int_q[7:0]     <= REG_WDATA;
			if (wr_fhi) frac_q[20:16]  <= REG_WDATA[4:0];
			if (wr_fmd) frac_q[15:8]   <= REG_WDATA;
			if (wr_flo) frac_q[7:0]    <= REG_WDATA;
		end
	end

	// Read data lands one cycle after the strobe and then holds
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) rdata_q <= 8'h00;
		else if (REG_RD) rdata_q <= rd_mux;
	end
	assign REG_RDATA = rdata_q;

	// ----------------------------------------------------------
	// Lock detection
	// ----------------------------------------------------------
	wire [PHERR_W-1:0] err_mag = PHASE_ERR[PHERR_W-1] ?
		PHERR_W'(-PHASE_ERR) : PHASE_ERR;
	wire in_win = win_q != 8'h00 && err_mag <= PHERR_W'(win_q);

	// Any sample outside the window drops lock at once
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) lock_q <= 1'b0;
		else if (PHASE_ERR_VALID) lock_q <= in_win;
	end
	assign LOCKED = lock_q;

	// ----------------------------------------------------------
	// Set selection and outputs
	// ----------------------------------------------------------
	wire use_acq = fast_q && !lock_q;
	wire [3:0] bw_sel = use_acq ? acquire_bandwidth_code_q : trkbw_q;
	wire [3:0] dmp_sel = use_acq ? damp_val(acqd_q, 1'b1)
		: damp_val(trkd_q, 1'b0);
	wire [2:0] gain_sel = 3'(gain_q) + 3'h1;
	wire [15:0] slope_sel = (slope_q == 2'h1) ? SLOPE_FAST_NS :
		(slope_q == 2'h2) ? SLOPE_SLOW_NS : 16'h0000;

	// Outputs registered, one cycle behind the configuration
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			BW_CODE     <= RST_BW;
			DAMPING     <= 4'h0;
			GAIN_HALVES <= 3'h2;
			SLOPE_LIMIT <= 16'h0000;
			FB_VALUE    <= {RST_INT, RST_FRAC};
		end else begin
			BW_CODE     <= bw_sel;
			DAMPING     <= dmp_sel;
			GAIN_HALVES <= gain_sel;
			SLOPE_LIMIT <= slope_sel;
			FB_VALUE    <= {int_q, frac_q};
		end
	end

	// ----------------------------------------------------------
	// History tick and holdover
	// ----------------------------------------------------------
	wire tick = tick_cnt_q == TICK_W'(HIST_CYCLES - 1);
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) tick_cnt_q <= '0;
		else tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
	end

	dlc_holdover u_hold (
		.clk         (SYS_CLK),
		.rst         (RESET),
		.tick        (tick),
		.freq_word   (FREQ_WORD),
		.holdover    (HOLDOVER),
		.mode        (hold_q),
		.avg_en      (avg_q),
		.hold_active (HOLD_ACTIVE),
		.hold_freq_q (HOLD_FREQ)
	);

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	sequence s_lock_lost;
		lock_q ##1 !lock_q;
	endsequence

	trk_damp_a: assert property (!use_acq && trkd_q == 3'h4
		|=> DAMPING == 4'ha)
		else $error("tracking damping wrong");
	acq_damp_a: assert property (use_acq && acqd_q == 3'h3
		|=> DAMPING == 4'h5)
		else $error("acquire damping wrong");
	gain_map_a: assert property (gain_q == 2'h0
		|=> GAIN_HALVES == 3'h1)
		else $error("gain scale wrong");
	slope_map_a: assert property (slope_q == 2'h2
		&& $stable(slope_q)
		|=> SLOPE_LIMIT == SLOPE_SLOW_NS)
		else $error("slope cap wrong");
	fast_off_a: assert property (!fast_q
		|=> BW_CODE == $past(trkbw_q))
		else $error("tracking set not used");
	fast_on_a: assert property (fast_q && !lock_q
		|=> BW_CODE == $past(acquire_bandwidth_code_q))
		else $error("acquire set not used");
	win_lock_a: assert property (PHASE_ERR_VALID && !in_win
		|=> !LOCKED)
		else $error("lock outside window");
	relock_a: assert property (s_lock_lost ##0 fast_q
		|=> BW_CODE == $past(acquire_bandwidth_code_q))
		else $error("loss did not reacquire");
	fb_join_a: assert property (wr_flo |=> ##1
		FB_VALUE[7:0] == $past(REG_WDATA, 2))
		else $error("fraction not joined");
	int_write_a: assert property (wr_ilo |=> ##1
		FB_VALUE[28:21] == $past(REG_WDATA, 2))
		else $error("integer part not applied");

endmodule : dlc_top
`default_nettype wire

//--- design/dlc_pkg.sv
/*
 * Constants and types shared by the loop configuration block.
 * Assumes a 50 MHz system clock and a byte-wide register port.
 */
package dlc_pkg;

	// ----------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------
	localparam logic [15:0] ADDR_MODE     = 16'h0023;
	localparam logic [15:0] ADDR_WIN      = 16'h0024;
	localparam logic [15:0] ADDR_INT_HI   = 16'h0025;
	localparam logic [15:0] ADDR_INT_LO   = 16'h0026;
	localparam logic [15:0] ADDR_FRAC_HI  = 16'h0028;
	localparam logic [15:0] ADDR_FRAC_MID = 16'h0029;
	localparam logic [15:0] ADDR_FRAC_LO  = 16'h002a;
	localparam logic [15:0] ADDR_BW       = 16'h002d;
	localparam logic [15:0] ADDR_DAMP     = 16'h002e;

	// ----------------------------------------------------------
	// Field positions (low bit of each field)
	// ----------------------------------------------------------
	localparam int SLOPE_LSB  = 6;
	localparam int HOLD_LSB   = 3;
	localparam int AVG_BIT    = 1;
	localparam int FAST_BIT   = 0;
	localparam int TRKD_LSB   = 5;
	localparam int ACQD_LSB   = 2;
	localparam int GAIN_LSB   = 0;
	localparam int TRKBW_LSB  = 4;
	localparam int ACQUIRE_BANDWIDTH_CODE_LSB  = 0;

	// ----------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------
	localparam logic [2:0]  RST_TRKD  = 3'h3;
	localparam logic [2:0]  RST_ACQD  = 3'h3;
	localparam logic [1:0]  RST_GAIN  = 2'h1;
	localparam logic [1:0]  RST_SLOPE = 2'h0;
	localparam logic [1:0]  RST_HOLD  = 2'h0;
	localparam logic        RST_AVG   = 1'h0;
	localparam logic        RST_FAST  = 1'h0;
	localparam logic [7:0]  RST_WIN   = 8'h3f;
	localparam logic [8:0]  RST_INT   = 9'h02d;
	localparam logic [20:0] RST_FRAC  = 21'h000000;
	localparam logic [3:0]  RST_BW    = 4'h7;

	// ----------------------------------------------------------
	// Widths, timing and fixed values
	// ----------------------------------------------------------
	localparam int FREQ_W     = 24;
	localparam int PHERR_W    = 12;
	localparam int TICK_W     = 23;
	localparam int AVG_SHIFT  = 4;
	localparam int CLK_HZ     = 50_000_000;
	localparam int HIST_MS    = 100;
	localparam int HIST_CYC   = CLK_HZ / 1000 * HIST_MS;
	localparam int SLOPE_FAST_US = 64;
	localparam int SLOPE_SLOW_US = 11;
	localparam logic [15:0] SLOPE_FAST_NS = 16'(SLOPE_FAST_US * 1000);
	localparam logic [15:0] SLOPE_SLOW_NS = 16'(SLOPE_SLOW_US * 1000);
	localparam logic [FREQ_W-1:0] CENTRE_WORD = 24'h800000;

	// Holdover estimate modes
	typedef enum logic [1:0] {
		HOLD_INSTANT = 2'h0,
		HOLD_FASTAVG = 2'h1,
		HOLD_RSVD    = 2'h2,
		HOLD_CENTRE  = 2'h3
	} dlc_hold_type;

	// Holdover estimator states
	typedef enum logic {HO_TRACK, HO_HOLD} dlc_ho_state_type;

endpackage : dlc_pkg

//--- design/dlc_holdover.sv
/*
 * Holdover estimator: keeps frequency history and picks the value
 * applied when holdover starts. Assumes the history tick is a
 * one-cycle pulse every 100 ms from the parent.
 */
`timescale 1ns/1ps
`default_nettype none
module dlc_holdover
	import dlc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// Loop side
	input  wire logic              tick,
	input  wire logic [FREQ_W-1:0] freq_word,
	input  wire logic              holdover,
	// Configuration
	input  wire logic [1:0]        mode,
	input  wire logic              avg_en,
	// Result
	output logic                   hold_active,
	output logic [FREQ_W-1:0]      hold_freq_q
);
	dlc_ho_state_type state_q;
	logic [FREQ_W-1:0] hist_q;
	logic [FREQ_W-1:0] prev_q;
	logic [FREQ_W-1:0] avg_q;
	logic              seeded_q;
	logic signed [FREQ_W:0] diff;
	logic signed [FREQ_W:0] step;
	logic [FREQ_W-1:0] avg_d;
	logic [FREQ_W-1:0] est;
	logic              entry;

	// ----------------------------------------------------------
	// Averaging and selection
	// ----------------------------------------------------------
	// Exponential average; difference taken one bit wider, so it never wraps
	assign diff  = $signed({1'b0, freq_word}) - $signed({1'b0, avg_q});
	assign step  = diff >>> AVG_SHIFT;
	assign avg_d = seeded_q ? avg_q + step[FREQ_W-1:0] : freq_word;
	assign entry = holdover && (state_q == HO_TRACK);
	// Reserved mode falls back to the live word, as if not averaging
	assign est = !avg_en ? freq_word :
		(mode == HOLD_INSTANT) ? prev_q :
		(mode == HOLD_FASTAVG) ? avg_q :
		(mode == HOLD_CENTRE)  ? CENTRE_WORD : freq_word;
	assign hold_active = (state_q == HO_HOLD);

	// ----------------------------------------------------------
	// History, held at each tick outside holdover; prev_q is at least 100 ms old
	// ----------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hist_q   <= '0;
			prev_q   <= '0;
			avg_q    <= '0;
			seeded_q <= 1'b0;
		end else if (tick && !hold_active) begin
			prev_q   <= hist_q;
			hist_q   <= freq_word;
			avg_q    <= avg_d;
			seeded_q <= 1'b1;
		end
	end

	// Capture the estimate once, on entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q     <= HO_TRACK;
			hold_freq_q <= '0;
		end else begin
			unique case (state_q)
				HO_TRACK: if (holdover) begin
					state_q     <= HO_HOLD;
					hold_freq_q <= est;
				end
				HO_HOLD: if (!holdover) state_q <= HO_TRACK;
			endcase
		end
	end

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_enter_on;
		entry && avg_en;
	endsequence

	instant_pick_a: assert property (s_enter_on
		##0 mode == HOLD_INSTANT
		|=> hold_active && hold_freq_q == $past(prev_q))
		else $error("instant holdover value wrong");
	centre_pick_a: assert property (s_enter_on
		##0 mode == HOLD_CENTRE
		|=> hold_freq_q == CENTRE_WORD)
		else $error("centre holdover value wrong");
	fastavg_pick_a: assert property (s_enter_on
		##0 mode == HOLD_FASTAVG
		|=> hold_freq_q == $past(avg_q))
		else $error("fast average value wrong");
	avg_off_a: assert property (entry && !avg_en
		|=> hold_freq_q == $past(freq_word))
		else $error("averaging not disabled");
	hold_keep_a: assert property (hold_active && holdover
		|=> hold_active && $stable(hold_freq_q))
		else $error("held value moved");

endmodule : dlc_holdover
`default_nettype wire

//--- sim/test_dlc_top.sv
/*
 * Self-checking bench for the loop configuration block: register
 * port, set selection, lock window, feedback value and holdover.
 * Assumes the block alone on SYS_CLK, history tick shortened to 16.
 */
`timescale 1ns/1ps
`default_nettype none
module test_dlc_top;
	import dlc_pkg::*;

	// ----------------------------------------------------------
	// Stimulus, observation and model state
	// ----------------------------------------------------------
	logic                sys_clk         = 1'b0;
	logic                reset           = 1'b1;
	logic [15:0]         reg_addr        = 16'h0000;
	logic [7:0]          reg_wdata       = 8'h00;
	logic                reg_wr          = 1'b0;
	logic                reg_rd          = 1'b0;
	logic [PHERR_W-1:0]  phase_err       = 12'h000;
	logic                phase_err_valid = 1'b0;
	logic [FREQ_W-1:0]   freq_word       = 24'h5a3c71;
	logic                holdover        = 1'b0;
	logic [7:0]          reg_rdata;
	logic                locked;
	logic [3:0]          bw_code;
	logic [3:0]          damping;
	logic [2:0]          gain_halves;
	logic [15:0]         slope_limit;
	logic [29:0]         fb_value;
	logic                hold_active;
	logic [FREQ_W-1:0]   hold_freq;
	int m_slope = 0, m_hold = 0, m_avg = 0, m_fast = 0, m_lock = 0;
	int m_win = 'h3f, m_int = 'h2d, m_frac = 0, m_tbw = 7, m_abw = 7;
	int m_td = 3, m_ad = 3, m_gain = 1;
	int seed = 10834;
	int fail_count = 0;
	int comparisons = 0;
	int w, e;
	logic [FREQ_W-1:0] hd;

	// Free-running 50 MHz clock
	always #10 sys_clk = ~sys_clk;

	// Design under test, history tick cut to 16 cycles for run time
	dlc_top #(.HIST_CYCLES(16)) uut (
		.SYS_CLK(sys_clk), .RESET(reset), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .PHASE_ERR(phase_err),
		.PHASE_ERR_VALID(phase_err_valid), .FREQ_WORD(freq_word),
		.HOLDOVER(holdover), .LOCKED(locked), .BW_CODE(bw_code),
		.DAMPING(damping), .GAIN_HALVES(gain_halves),
		.SLOPE_LIMIT(slope_limit), .FB_VALUE(fb_value),
		.HOLD_ACTIVE(hold_active), .HOLD_FREQ(hold_freq)
	);

	// ----------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------
	// Code 011 means 5 only in the acquire set
	function automatic int damp_of(input int c, input int acq);
		case (c)
			1: return 1;
			2: return 2;
			3: return acq ? 5 : 0;
			4: return 10;
			default: return 0;
		endcase
	endfunction : damp_of

	// Reserved bits and unmapped bytes read as zero
	function automatic logic [7:0] exp_reg(input logic [15:0] a);
		case (a)
			ADDR_MODE: return 8'(m_slope*64 + m_hold*8 + m_avg*2 + m_fast);
			ADDR_WIN: return 8'(m_win);
			ADDR_INT_HI: return 8'(m_int / 256);
			ADDR_INT_LO: return 8'(m_int);
			ADDR_FRAC_HI: return 8'(m_frac / 65536);
			ADDR_FRAC_MID: return 8'(m_frac / 256);
			ADDR_FRAC_LO: return 8'(m_frac);
			ADDR_BW: return 8'(m_tbw*16 + m_abw);
			ADDR_DAMP: return 8'(m_td*32 + m_ad*4 + m_gain);
			default: return 8'h00;
		endcase
	endfunction : exp_reg

	// Each byte takes effect alone, no shadowing
	task automatic model_write(input logic [15:0] a, input logic [7:0] d);
		case (a)
			ADDR_MODE: begin
				m_slope = d[7:6];
				m_hold = d[4:3];
				m_avg = d[1];
				m_fast = d[0];
			end
			ADDR_WIN: m_win = d;
			ADDR_INT_HI: m_int = (m_int & 'hff) | (int'(d[0]) << 8);
			ADDR_INT_LO: m_int = (m_int & 'h100) | int'(d);
			ADDR_FRAC_HI: m_frac = (m_frac & 'hffff) | (int'(d[4:0]) << 16);
			ADDR_FRAC_MID: m_frac = (m_frac & 'h1f00ff) | (int'(d) << 8);
			ADDR_FRAC_LO: m_frac = (m_frac & 'h1fff00) | int'(d);
			ADDR_BW: begin
				m_tbw = d[7:4];
				m_abw = d[3:0];
			end
			ADDR_DAMP: begin
				m_td = d[7:5];
				m_ad = d[4:2];
				m_gain = d[1:0];
			end
			default: ;
		endcase
	endtask : model_write

	// ----------------------------------------------------------
	// Drivers and comparisons
	// ----------------------------------------------------------
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_val

	// Register read result; byte wide, compared with no padding slack
	task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
		check_val(32'(got), 32'(exp), "read data");
	endtask : check_reg

	// Holdover result: state flag or applied frequency word
	task automatic check_hold(input logic [23:0] got,
		input logic [23:0] exp, input string what);
		check_val(32'(got), 32'(exp), what);
	endtask : check_hold

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		model_write(a, d);
	endtask : wr

	task automatic rd_chk(input logic [15:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		#1;
		check_reg(reg_rdata, exp_reg(a));
	endtask : rd_chk

	// Derived settings lag writes and samples by up to two cycles
	task automatic settle();
		int acq;
		repeat (3) @(posedge sys_clk);
		#1;
		acq = m_fast && !m_lock;
		check_val(locked, m_lock, "lock");
		check_val(bw_code, acq ? m_abw : m_tbw, "bandwidth");
		check_val(damping, damp_of(acq ? m_ad : m_td, acq), "damping");
		check_val(gain_halves, m_gain + 1, "gain");
		check_val(slope_limit, m_slope == 1 ? 64000 :
			m_slope == 2 ? 11000 : 0, "slope");
		check_val(fb_value, (m_int << 21) | m_frac, "feedback");
	endtask : settle

	task automatic sample(input int err);
		@(posedge sys_clk);
		phase_err <= 12'(err);
		phase_err_valid <= 1'b1;
		@(posedge sys_clk);
		phase_err_valid <= 1'b0;
		m_lock = (err <= m_win) && (-err <= m_win) && (m_win != 0);
		settle();
	endtask : sample

	// Live word is restored on exit so history stays predictable
	task automatic hold_chk(input logic [23:0] f, input logic [23:0] x);
		@(posedge sys_clk);
		holdover <= 1'b1;
		freq_word <= f;
		@(posedge sys_clk);
		#1;
		check_hold(24'(hold_active), 24'h000001, "hold entry");
		check_hold(hold_freq, x, "hold value");
		@(posedge sys_clk);
		freq_word <= ~f;
		repeat (3) @(posedge sys_clk);
		#1;
		check_hold(hold_freq, x, "hold kept");
		@(posedge sys_clk);
		holdover <= 1'b0;
		freq_word <= f;
		repeat (2) @(posedge sys_clk);
		#1;
		check_hold(24'(hold_active), 24'h000000, "hold exit");
	endtask : hold_chk

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask : end_test

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// ----------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		settle();
		for (int a = 'h20; a < 'h30; a++)
			rd_chk(16'(a));
		end_test("reset");
		// All damping and gain codes, first tracking then acquire set
		for (int f = 0; f < 2; f++) begin
			wr(ADDR_MODE, 8'(f));
			for (int i = 0; i < 8; i++) begin
				wr(ADDR_DAMP, {3'(i), 3'(7 - i), 2'(i)});
				wr(ADDR_BW, 8'($random(seed)));
				settle();
			end
		end
		end_test("damping");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_MODE, 8'(i * 64 + 'h24));
			settle();
			rd_chk(ADDR_MODE);
		end
		end_test("slope");
		// Window edges, sign, loss of lock, ignored sample change
		wr(ADDR_MODE, 8'h01);
		wr(ADDR_BW, 8'h5a);
		wr(ADDR_DAMP, 8'h8e);
		wr(ADDR_WIN, 8'h20);
		sample(32);
		sample(-33);
		sample(-32);
		@(posedge sys_clk);
		phase_err <= 12'h7ff;
		settle();
		for (int i = 0; i < 20; i++) begin
			w = $random(seed) & 'hff;
			if (w == 0)
				w = 1;
			wr(ADDR_WIN, 8'(w));
			e = $random(seed) % 301;
			sample(e);
		end
		end_test("lock");
		for (int i = 0; i < 8; i++) begin
			for (int a = 'h25; a < 'h2b; a++)
				wr(16'(a), 8'($random(seed)));
			settle();
			for (int a = 'h25; a < 'h2b; a++)
				rd_chk(16'(a));
		end
		end_test("feedback");
		// Live word has been constant since reset
		hd = 24'($random(seed));
		wr(ADDR_MODE, 8'h0a);
		hold_chk(24'h5a3c71, 24'h5a3c71);
		wr(ADDR_MODE, 8'h02);
		hold_chk(hd, 24'h5a3c71);
		wr(ADDR_MODE, 8'h00);
		hold_chk(~hd, ~hd);
		wr(ADDR_MODE, 8'h1a);
		hold_chk(hd, CENTRE_WORD);
		wr(ADDR_MODE, 8'h12);
		hold_chk(hd, hd);
		end_test("holdover");
		finish_test();
	end

	// Run needs about 700 cycles; cut a hang well beyond that
	initial begin
		#(20 * 50000);
		fail_count++;
		finish_test();
	end

endmodule : test_dlc_top
`default_nettype wire
